// File: hbc_bridge_ctrl.sv
// H-bridge decode, current regulation and fault latching
// Contract
// (RL1) Awake and enabled, output A follows polarity A and output B follows polarity B, equal inputs give both low or both high.
// (RL2) A disable input asserted switches the whole bridge off and pulls the fault flag low whatever the polarity inputs.
// (RL3) Latched shutdowns and the fault flag clear only when the host toggles a disable input, after which decoding resumes.
//        Sleep or an undervoltage also clears a latched shutdown here, without a disable toggle.
// (RL4) Undervoltage tri-states both outputs and pulls the fault flag low regardless of all inputs but enable.
// Undervoltage during the wake-up delay pulls the flag low here only after the delay ends.
// (RL5) When undervoltage ends the flag is released and the outputs follow the inputs again without host action.
// (RL6) A short or overtemperature latches both outputs off with the flag low, ignoring polarity until cleared.
// (RL7) Low-side current at the regulation threshold tri-states the bridge for a fixed off time and then re-enables it.
// (RL8) After every output activation the regulation threshold is ignored for a blanking time.
// (RL9) A short threshold crossed during blanking immediately forces the latched shutdown.
// (RL10) Regulation is a constant-off-time scheme whose switching rate never exceeds the maximum frequency.
// (RL11) The host modulates the load by holding one polarity input high and pulsing the other.
// (RL12) Enable low puts the part to sleep with the outputs off and the fault flag released.
// (RL13) Undriven inputs read polarity high, both disables asserted and enable low.
// (RL14) After power-up or leaving sleep the outputs stay off for a wake-up delay before the inputs are honoured.
`timescale 1ns/100ps
`include "hbc_map.svh"
module hbc_bridge_ctrl #(
    parameter int TW = `HBC_TMR_W,
    parameter int TOFF_CYC = `HBC_TOFF_CYC,
    parameter int BLANK_CYC = `HBC_BLANK_CYC,
    parameter int PERIOD_CYC = `HBC_PERIOD_CYC,
    parameter int WAKE_CYC = `HBC_WAKE_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Host control pins and their driven flags
    input wire hbc_pkg::hbc_ctrl_t ctrl_i,
    input wire hbc_pkg::hbc_ctrl_t ctrl_drv_i,
    // Analog detectors
    input wire hbc_pkg::hbc_det_t det_i,
    // Half-bridge outputs
    output hbc_pkg::hbc_pin_t half_bridge_a_o,
    output hbc_pkg::hbc_pin_t half_bridge_b_o,
    // Open-drain fault flag
    output logic fault_flag_n_o,
    output logic fault_flag_oe_n_o
);

    // ==========================================================
    // Effective inputs
    hbc_pkg::hbc_ctrl_t ctl;
    logic dis;
    logic uv;
    logic trip;
    logic reg_hit;

    always_comb begin
        ctl.enable = ctrl_drv_i.enable ? ctrl_i.enable : `HBC_DEF_EN; // RL13
        ctl.disable_active_high = ctrl_drv_i.disable_active_high ?
            ctrl_i.disable_active_high : `HBC_DEF_DIS_HIGH; // RL13
        ctl.disable_active_low_n = ctrl_drv_i.disable_active_low_n ?
            ctrl_i.disable_active_low_n : `HBC_DEF_DIS_LOW_N; // RL13
        ctl.polarity_in_a = ctrl_drv_i.polarity_in_a ?
            ctrl_i.polarity_in_a : `HBC_DEF_POL; // RL13
        ctl.polarity_in_b = ctrl_drv_i.polarity_in_b ?
            ctrl_i.polarity_in_b : `HBC_DEF_POL; // RL13
    end

    assign dis = ctl.disable_active_high || !ctl.disable_active_low_n; // RL2
    assign uv = det_i.undervoltage;
    assign trip = det_i.high_side_short_threshold ||
        det_i.low_side_short_threshold || det_i.thermal_trip;
    assign reg_hit = det_i.low_side_regulation_threshold;

    // ==========================================================
    // Timers
    hbc_pkg::hbc_state_t state_reg;
    hbc_pkg::hbc_state_t state_next;
    hbc_pkg::hbc_state_t resume_state;
    logic [`HBC_NUM_TMR-1:0] tmr_load;
    logic [`HBC_NUM_TMR-1:0] tmr_done;
    logic [TW-1:0] tmr_val [`HBC_NUM_TMR];
    logic activate;

    assign tmr_val[`HBC_TMR_BLANK] = TW'(BLANK_CYC);
    assign tmr_val[`HBC_TMR_TOFF] = TW'(TOFF_CYC);
    assign tmr_val[`HBC_TMR_PERIOD] = TW'(PERIOD_CYC);
    assign tmr_val[`HBC_TMR_WAKE] = TW'(WAKE_CYC);

    // A polarity change counts as a fresh activation, so blanking restarts
    assign activate = (state_next == hbc_pkg::HBC_RUN) &&
        ((state_reg != hbc_pkg::HBC_RUN) ||
         (ctl.polarity_in_a != half_bridge_a_o.level) ||
         (ctl.polarity_in_b != half_bridge_b_o.level));
    assign tmr_load[`HBC_TMR_BLANK] = activate; // RL8
    assign tmr_load[`HBC_TMR_TOFF] = (state_next == hbc_pkg::HBC_REGOFF) &&
        (state_reg != hbc_pkg::HBC_REGOFF); // RL7
    assign tmr_load[`HBC_TMR_PERIOD] = tmr_load[`HBC_TMR_TOFF]; // RL10
    assign tmr_load[`HBC_TMR_WAKE] = (state_next == hbc_pkg::HBC_WAKE) &&
        (state_reg != hbc_pkg::HBC_WAKE); // RL14

    genvar g;
    generate
        for (g = 0; g < `HBC_NUM_TMR; g = g + 1) begin : g_tmr
            hbc_timer #(
                .W(TW)
            ) u_tmr (
                .ref_clk_i(ref_clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .load_i(tmr_load[g]),
                .load_val_i(tmr_val[g]),
                .done_o(tmr_done[g])
            );
        end
    endgenerate

    // ==========================================================
    // Control state machine
    always_comb begin
        if (uv) begin
            resume_state = hbc_pkg::HBC_UNDERV;
        end else if (dis) begin
            resume_state = hbc_pkg::HBC_DISABLED;
        end else begin
            resume_state = hbc_pkg::HBC_RUN;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            hbc_pkg::HBC_SLEEP: begin
                if (ctl.enable) begin
                    state_next = hbc_pkg::HBC_WAKE; // RL14
                end
            end
            hbc_pkg::HBC_WAKE: begin
                if (tmr_done[`HBC_TMR_WAKE]) begin
                    state_next = resume_state; // RL14
                end
            end
            hbc_pkg::HBC_UNDERV: begin
                if (!uv) begin
                    state_next = resume_state; // RL5
                end
            end
            hbc_pkg::HBC_RUN: begin
                if (dis) begin
                    state_next = hbc_pkg::HBC_DISABLED; // RL2
                end else if (trip) begin
                    state_next = hbc_pkg::HBC_LATCHED; // RL6 RL9
                end else if (reg_hit && tmr_done[`HBC_TMR_BLANK] &&
                        tmr_done[`HBC_TMR_PERIOD]) begin
                    state_next = hbc_pkg::HBC_REGOFF; // RL7 RL8 RL10
                end
            end
            hbc_pkg::HBC_REGOFF: begin
                if (dis) begin
                    state_next = hbc_pkg::HBC_DISABLED; // RL2
                end else if (trip) begin
                    state_next = hbc_pkg::HBC_LATCHED; // RL6
                end else if (tmr_done[`HBC_TMR_TOFF]) begin
                    state_next = hbc_pkg::HBC_RUN; // RL7
                end
            end
            hbc_pkg::HBC_DISABLED: begin
                if (!dis) begin
                    state_next = hbc_pkg::HBC_RUN; // RL3
                end
            end
            hbc_pkg::HBC_LATCHED: begin
                // Besides sleep and undervoltage below, only a disable edge opens the latch
                if (dis) begin
                    state_next = hbc_pkg::HBC_DISABLED; // RL3
                end
            end
            default: begin
                state_next = hbc_pkg::HBC_SLEEP;
            end
        endcase
        if (!ctl.enable) begin
            state_next = hbc_pkg::HBC_SLEEP; // RL12
        end else if (uv && (state_reg != hbc_pkg::HBC_SLEEP) &&
                (state_reg != hbc_pkg::HBC_WAKE)) begin
            state_next = hbc_pkg::HBC_UNDERV; // RL4
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= hbc_pkg::HBC_SLEEP;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Pin registers, computed from the next state so pins track it
    logic drive;
    logic flt;

    assign drive = (state_next == hbc_pkg::HBC_RUN);
    assign flt = (state_next == hbc_pkg::HBC_DISABLED) ||
        (state_next == hbc_pkg::HBC_LATCHED) ||
        (state_next == hbc_pkg::HBC_UNDERV);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            half_bridge_a_o.level <= `HBC_RST_LEVEL;
            half_bridge_a_o.oe_n <= `HBC_RST_OE_N;
            half_bridge_b_o.level <= `HBC_RST_LEVEL;
            half_bridge_b_o.oe_n <= `HBC_RST_OE_N;
        end else if (ce_i) begin
            half_bridge_a_o.level <= drive & ctl.polarity_in_a; // RL1
            half_bridge_a_o.oe_n <= !drive; // RL6
            half_bridge_b_o.level <= drive & ctl.polarity_in_b; // RL1
            half_bridge_b_o.oe_n <= !drive; // RL6
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fault_flag_n_o <= `HBC_RST_FAULT_N;
            fault_flag_oe_n_o <= `HBC_RST_FAULT_N;
        end else if (ce_i) begin
            fault_flag_n_o <= !flt; // RL2 RL4 RL6
            fault_flag_oe_n_o <= !flt; // RL5 RL12
        end
    end

    // ==========================================================
    // Interval counters watched by the checks below
    logic [TW-1:0] off_cnt;
    logic [TW-1:0] run_cnt;
    logic [TW-1:0] per_cnt;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            off_cnt <= '0;
        end else if (ce_i) begin
            off_cnt <= (state_reg == hbc_pkg::HBC_REGOFF) ?
                off_cnt + TW'(1) : '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            run_cnt <= '1;
            per_cnt <= '1;
        end else if (ce_i) begin
            if (tmr_load[`HBC_TMR_BLANK]) begin
                run_cnt <= '0;
            end else if (run_cnt != '1) begin
                run_cnt <= run_cnt + TW'(1);
            end
            if (tmr_load[`HBC_TMR_PERIOD]) begin
                per_cnt <= '0;
            end else if (per_cnt != '1) begin
                per_cnt <= per_cnt + TW'(1);
            end
        end
    end

    // ==========================================================
    // Checks
    logic awake;
    logic bridge_off;
    assign awake = (state_reg != hbc_pkg::HBC_SLEEP) &&
        (state_reg != hbc_pkg::HBC_WAKE);
    assign bridge_off = half_bridge_a_o.oe_n && half_bridge_b_o.oe_n;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_enter_regoff;
        ce_i && (state_reg == hbc_pkg::HBC_RUN) &&
            (state_next == hbc_pkg::HBC_REGOFF);
    endsequence
    sequence s_leave_regoff;
        ce_i && (state_reg == hbc_pkg::HBC_REGOFF) &&
            (state_next == hbc_pkg::HBC_RUN);
    endsequence
    sequence s_quiet;
        ce_i && ctl.enable && !uv && !dis;
    endsequence
    polarity_decode_a: assert property ( // RL1
        (ce_i && (state_next == hbc_pkg::HBC_RUN)) |=>
            (half_bridge_a_o.level == $past(ctl.polarity_in_a)) &&
            (half_bridge_b_o.level == $past(ctl.polarity_in_b)) &&
            !half_bridge_a_o.oe_n && !half_bridge_b_o.oe_n)
        else $error("bridge does not follow polarity inputs");
    disable_off_a: assert property ( // RL2
        (ce_i && awake && ctl.enable && dis) |=>
            bridge_off && !fault_flag_n_o && !fault_flag_oe_n_o)
        else $error("disable did not switch bridge off with fault");
    latch_hold_a: assert property ( // RL3
        (state_reg == hbc_pkg::HBC_LATCHED) ##0 s_quiet |=>
            (state_reg == hbc_pkg::HBC_LATCHED) && bridge_off)
        else $error("latched shutdown left without disable toggle");
    latch_clear_a: assert property ( // RL3
        (state_reg == hbc_pkg::HBC_DISABLED) ##0 s_quiet |=>
            (state_reg == hbc_pkg::HBC_RUN) && fault_flag_n_o &&
            !half_bridge_a_o.oe_n && !half_bridge_b_o.oe_n)
        else $error("disable toggle did not restore decoding");
    uv_tristate_a: assert property ( // RL4
        (ce_i && awake && ctl.enable && uv) |=>
            bridge_off && !fault_flag_n_o)
        else $error("undervoltage did not tri-state with fault");
    uv_recover_a: assert property ( // RL5
        (state_reg == hbc_pkg::HBC_UNDERV) ##0 s_quiet |=>
            fault_flag_n_o && (state_reg == hbc_pkg::HBC_RUN))
        else $error("no automatic recovery after undervoltage");
    trip_latch_a: assert property ( // RL6
        (ce_i && (state_reg == hbc_pkg::HBC_RUN) && trip && ctl.enable &&
            !uv && !dis) |=> (state_reg == hbc_pkg::HBC_LATCHED) &&
            bridge_off && !fault_flag_n_o)
        else $error("trip did not latch the bridge off");
    off_time_a: assert property ( // RL7
        s_leave_regoff |-> (off_cnt == TW'(TOFF_CYC)))
        else $error("regulation off time has wrong length");
    off_bridge_a: assert property ( // RL7
        s_enter_regoff |=> bridge_off && fault_flag_n_o)
        else $error("regulation off did not tri-state the bridge");
    blank_window_a: assert property ( // RL8
        s_enter_regoff |-> (run_cnt >= TW'(BLANK_CYC)))
        else $error("regulation acted inside blanking");
    blank_short_a: assert property ( // RL9
        (ce_i && (state_reg == hbc_pkg::HBC_RUN) && !dis && !uv &&
            ctl.enable && (run_cnt < TW'(BLANK_CYC)) &&
            det_i.high_side_short_threshold) |->
            (state_next == hbc_pkg::HBC_LATCHED))
        else $error("short in blanking not latched");
    rate_limit_a: assert property ( // RL10
        s_enter_regoff |-> (per_cnt >= TW'(PERIOD_CYC)))
        else $error("regulation switching rate too high");
    sleep_quiet_a: assert property ( // RL12 RL13
        (ce_i && !ctl.enable) |=> bridge_off && fault_flag_n_o &&
            fault_flag_oe_n_o && (state_reg == hbc_pkg::HBC_SLEEP))
        else $error("sleep does not release bridge and flag");
    wake_delay_a: assert property ( // RL14
        (ce_i && (state_reg == hbc_pkg::HBC_SLEEP) && ctl.enable) |=>
            (state_reg == hbc_pkg::HBC_WAKE) [*8] ##0 bridge_off)
        else $error("bridge left wake-up delay too early");
endmodule

// File: hbc_host_model.sv
// Host controller model driving the bridge control pins
`timescale 1ns/100ps
module hbc_host_model #(
    parameter int HALF = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Requested levels, drive flags, modulation request
    input wire hbc_pkg::hbc_ctrl_t cmd_i,
    input wire hbc_pkg::hbc_ctrl_t drv_i,
    input wire logic pwm_en_i,
    // Pins toward the bridge
    output hbc_pkg::hbc_ctrl_t ctrl_o,
    output hbc_pkg::hbc_ctrl_t ctrl_drv_o
);
    hbc_pkg::hbc_ctrl_t pins_reg = 5'h00;
    hbc_pkg::hbc_ctrl_t drv_reg = 5'h00;
    int cnt_reg = 0;
    logic pwm_reg = 1'h0;

    assign ctrl_o = pins_reg;
    assign ctrl_drv_o = drv_reg;

    // ==========================================================
    // Pin levels
    // Released pins show the inverse of the request, never a kind default
    always @(posedge ref_clk_i) begin
        drv_reg <= drv_i;
        pins_reg <= (cmd_i & drv_i) | (~cmd_i & ~drv_i);
        if (pwm_en_i) begin
            pins_reg.polarity_in_a <= 1'h1;
            pins_reg.polarity_in_b <= pwm_reg;
        end
    end

    // ==========================================================
    // Modulation toggle timer
    always @(posedge ref_clk_i) begin
        if (sys_rst_i || !pwm_en_i) begin
            cnt_reg <= 0;
        end else if (cnt_reg == HALF - 1) begin
            cnt_reg <= 0;
            pwm_reg <= ~pwm_reg;
        end else begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule

// File: hbc_map.svh
// Timing counts, default pin levels and timer slots of the H-bridge control
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

// ==========================================================
// Time base
`define HBC_CLK_NS 8

// ==========================================================
// Times in their own unit
`define HBC_TOFF_NS 20500
`define HBC_BLANK_NS 16500
`define HBC_WAKE_NS 1000000
`define HBC_FMAX_KHZ 20
`define HBC_PERIOD_NS (1000000 / `HBC_FMAX_KHZ)

// ==========================================================
// Cycle counts, least times rounded up
`define HBC_TOFF_CYC ((`HBC_TOFF_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_BLANK_CYC ((`HBC_BLANK_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_WAKE_CYC ((`HBC_WAKE_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_PERIOD_CYC ((`HBC_PERIOD_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)

// ==========================================================
// Timer width and slots
`define HBC_TMR_W 17
`define HBC_NUM_TMR 4
`define HBC_TMR_BLANK 0
`define HBC_TMR_TOFF 1
`define HBC_TMR_PERIOD 2
`define HBC_TMR_WAKE 3

// ==========================================================
// Levels of undriven inputs and reset levels of the pins
`define HBC_DEF_EN 1'h0
`define HBC_DEF_DIS_HIGH 1'h1
`define HBC_DEF_DIS_LOW_N 1'h0
`define HBC_DEF_POL 1'h1
`define HBC_RST_LEVEL 1'h0
`define HBC_RST_OE_N 1'h1
`define HBC_RST_FAULT_N 1'h1

`endif

// File: hbc_pkg.sv
// Types shared by the H-bridge control files
package hbc_pkg;

    // ==========================================================
    // Host control pins
    typedef struct packed {
        logic enable;
        logic disable_active_high;
        logic disable_active_low_n;
        logic polarity_in_a;
        logic polarity_in_b;
    } hbc_ctrl_t;

    // ==========================================================
    // Analog detector outputs
    typedef struct packed {
        logic undervoltage;
        logic low_side_regulation_threshold;
        logic high_side_short_threshold;
        logic low_side_short_threshold;
        logic thermal_trip;
    } hbc_det_t;

    // ==========================================================
    // One half-bridge pin
    typedef struct packed {
        logic level;
        logic oe_n;
    } hbc_pin_t;

    // ==========================================================
    // Control states
    typedef enum logic [6:0] {
        HBC_SLEEP    = 7'h01,
        HBC_WAKE     = 7'h02,
        HBC_RUN      = 7'h04,
        HBC_REGOFF   = 7'h08,
        HBC_DISABLED = 7'h10,
        HBC_LATCHED  = 7'h20,
        HBC_UNDERV   = 7'h40
    } hbc_state_t;

endpackage

// File: hbc_timer.sv
// Loadable down-counter used for the bridge timing intervals
`timescale 1ns/100ps
module hbc_timer #(
    parameter int W = 17
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Load request
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    // Expiry
    output logic done_o
);

    logic [W-1:0] count_reg;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            count_reg <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                count_reg <= load_val_i;
            end else if (count_reg != '0) begin
                count_reg <= count_reg - W'(1);
            end
        end
    end

    assign done_o = (count_reg == '0);

endmodule

// File: hbridge_control_fault_logic_tb_top.sv
// Self-checking bench of the H-bridge control block
`timescale 1ns/100ps
module hbridge_control_fault_logic_tb_top;
    localparam int TOFF = 20;
    localparam int BLANK = 16;
    localparam int PER = 50;
    localparam int WAKE = 30;
    localparam logic [5:0] OFF_F = 6'h28;
    localparam logic [5:0] OFF_S = 6'h2B;
    logic ref_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic pwm_en = 1'h0;
    logic ce = 1'h1;
    hbc_pkg::hbc_ctrl_t cmd = 5'h00;
    hbc_pkg::hbc_ctrl_t drv = 5'h00;
    hbc_pkg::hbc_ctrl_t ctrl;
    hbc_pkg::hbc_ctrl_t ctrl_drv;
    hbc_pkg::hbc_det_t det = 5'h00;
    hbc_pkg::hbc_pin_t pa;
    hbc_pkg::hbc_pin_t pb;
    logic flag_n;
    logic flag_oe_n;
    int bad_count = 0;
    int n_checks = 0;

    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    hbc_host_model host (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd),
        .drv_i(drv), .pwm_en_i(pwm_en), .ctrl_o(ctrl),
        .ctrl_drv_o(ctrl_drv)
    );

    hbc_bridge_ctrl #(
        .TOFF_CYC(TOFF), .BLANK_CYC(BLANK), .PERIOD_CYC(PER),
        .WAKE_CYC(WAKE)
    ) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .ctrl_i(ctrl), .ctrl_drv_i(ctrl_drv), .det_i(det),
        .half_bridge_a_o(pa), .half_bridge_b_o(pb),
        .fault_flag_n_o(flag_n), .fault_flag_oe_n_o(flag_oe_n)
    );

    // ==========================================================
    // Helpers
    function automatic logic [5:0] pins();
        return {pa.oe_n, pa.level, pb.oe_n, pb.level, flag_n, flag_oe_n};
    endfunction

    function automatic logic [5:0] run_pins(input logic a, input logic b);
        return {1'h0, a, 1'h0, b, 2'h3};
    endfunction

    task automatic ck(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Host register plus input sampling: four edges covers the latency
    task automatic set(input logic [4:0] c);
        @(posedge ref_clk_i);
        cmd <= c;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_wake();
        int n;
        @(posedge ref_clk_i);
        cmd <= 5'h16;
        for (n = 1; n < 200 && pins() !== run_pins(1'h1, 1'h0); n++) begin
            @(posedge ref_clk_i);
            #1;
            if (pins() !== run_pins(1'h1, 1'h0))
                ck(pins() === OFF_S, "outputs driven during wake");
        end
        ck(n > WAKE && n < WAKE + 7, "wake delay length");
        if (n >= 200)
            print_verdict();
    endtask

    task automatic t_decode();
        for (int i = 0; i < 4; i++) begin
            set({3'h5, i[1:0]});
            ck(pins() === run_pins(i[1], i[0]), "decode");
        end
        @(posedge ref_clk_i);
        drv <= 5'h1C;
        set(5'h17);
        ck(pins() === run_pins(1'h1, 1'h1), "floating polarity");
        @(posedge ref_clk_i);
        drv <= 5'h1F;
        set(5'h16);
    endtask

    task automatic t_dis();
        set(5'h1E);
        ck(pins() === OFF_F, "high disable");
        set(5'h16);
        ck(pins() === run_pins(1'h1, 1'h0), "resume");
        set(5'h12);
        ck(pins() === OFF_F, "low disable");
        set(5'h16);
        ck(pins() === run_pins(1'h1, 1'h0), "resume");
    endtask

    // Clock enable low must hold every output, disable included
    task automatic t_ce();
        @(posedge ref_clk_i);
        ce <= 1'h0;
        set(5'h1E);
        ck(pins() === run_pins(1'h1, 1'h0), "clock enable hold");
        @(posedge ref_clk_i);
        ce <= 1'h1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        ck(pins() === OFF_F, "disable after clock enable");
    endtask

    task automatic t_latch();
        logic [4:0] trips [3] = '{5'h01, 5'h02, 5'h04};
        for (int j = 0; j < 3; j++) begin
            set(5'h15);
            @(posedge ref_clk_i);
            det <= trips[j];
            @(posedge ref_clk_i);
            det <= 5'h00;
            set(5'h16);
            ck(pins() === OFF_F, "latched off");
            set(5'h1E);
            ck(pins() === OFF_F, "disabled");
            set(5'h16);
            ck(pins() === run_pins(1'h1, 1'h0), "latch cleared");
        end
    endtask

    task automatic t_uv();
        @(posedge ref_clk_i);
        det <= 5'h10;
        set(5'h15);
        ck(pins() === OFF_F, "undervoltage");
        @(posedge ref_clk_i);
        det <= 5'h00;
        repeat (4) @(posedge ref_clk_i);
        #1;
        ck(pins() === run_pins(1'h0, 1'h1), "uv recovery");
    endtask

    // Threshold held high: off times repeat, spaced by the period
    task automatic t_reg();
        int first;
        int last;
        int run;
        int nof;
        first = -1;
        last = -PER;
        run = 0;
        nof = 0;
        @(posedge ref_clk_i);
        cmd <= 5'h16;
        repeat (2) @(posedge ref_clk_i);
        det <= 5'h08;
        for (int t = 2; t < 220; t++) begin
            @(negedge ref_clk_i);
            ck(flag_n === 1'h1, "flag during regulation");
            if (pa.oe_n === 1'h1) begin
                if (run == 0) begin
                    if (first < 0)
                        first = t;
                    ck(t - last >= PER, "switching too fast");
                    last = t;
                    nof++;
                end
                run++;
            end else if (run != 0) begin
                ck(run == TOFF + 1, "off time");
                ck(pins() === run_pins(1'h1, 1'h0), "re-enable");
                run = 0;
            end
        end
        ck(first >= BLANK && first < BLANK + 7, "blanking");
        ck(nof >= 2, "regulation count");
        @(posedge ref_clk_i);
        det <= 5'h00;
    endtask

    task automatic t_pwm();
        int ni;
        int no;
        logic pi;
        logic po;
        ni = 0;
        no = 0;
        @(posedge ref_clk_i);
        pwm_en <= 1'h1;
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        pi = ctrl.polarity_in_b;
        po = pb.level;
        repeat (120) begin
            @(negedge ref_clk_i);
            ni += int'(ctrl.polarity_in_b !== pi);
            no += int'(pb.level !== po);
            ck(pa.level === 1'h1, "held side");
            pi = ctrl.polarity_in_b;
            po = pb.level;
        end
        ck(ni > 10 && no >= ni - 1 && no <= ni + 1, "follow");
        @(posedge ref_clk_i);
        pwm_en <= 1'h0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'h0;
        repeat (3) @(posedge ref_clk_i);
        #1;
        ck(pins() === OFF_S, "floating pins");
        @(posedge ref_clk_i);
        drv <= 5'h1F;
        set(5'h0E);
        ck(pins() === OFF_S, "sleep");
        t_wake();
        t_decode();
        t_dis();
        t_ce();
        t_latch();
        t_uv();
        t_reg();
        t_pwm();
        set(5'h0E);
        ck(pins() === OFF_S, "sleep over disable");
        print_verdict();
    end
endmodule
